/* design/sfc_top.sv */
`timescale 1ns/100ps
// Behaviour
// [RULE1] disable write of one clears enable
// [RULE2] mask reads enables, resets to zero
// [RULE3] irq high when enabled flag set
// [RULE4] software loads receive pointer first
// [RULE5] zero receive count blocks receive DMA
// [RULE6] software loads transmit pointer first
// [RULE7] zero transmit count blocks transmit DMA
// [RULE8] each word advances pointer, decrements count
// [RULE9] idle clock level follows polarity bit
// [RULE10] phase bit picks change and sample edges
// [RULE11] word length 8 to 16 bits
// [RULE12] serial clock is master over twice divider
// [RULE13] divider zero or one stops clock
// [RULE14] master clock is system or over 32
// [RULE15] select to clock delay, zero half period
// [RULE16] gap 32 times field, zero gives four
// [RULE17] gap before release, select held between
// [RULE18] format register per group of four selects
module sfc_top (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   output logic             IRQ,
   input  wire logic        RX_FULL,      // status flags from serializer
   input  wire logic        TX_EMPTY,
   input  wire logic        MODE_FAULT,
   input  wire logic        OVERRUN,
   input  wire logic        START,        // serializer has a word to send
   input  wire logic        SAME_PERIPH,  // next word to same peripheral
   input  wire logic [3:0]  PERIPH,       // decoded peripheral number
   output sfc_pkg::sfc_dma_t DMA,
   input  wire logic        DMA_ACK,
   output logic             SERIAL_CLOCK_LINE,
   output logic             SELECT_ACTIVE,
   output logic             SHIFT_OUT,    // one-cycle: change data now
   output logic             SAMPLE_IN,    // one-cycle: capture data now
   output logic             WORD_DONE,
   output logic [4:0]       WORD_BITS
);
   typedef struct packed {
      logic [3:0]  flags;
      logic [3:0]  enable;
      logic [31:0] rx_addr;
      logic [31:0] rx_count;
      logic [31:0] tx_addr;
      logic [31:0] tx_count;
      logic [3:0][31:0] csf;
      logic        slow;
      logic [4:0]  pre;
      logic [7:0]  baud_cnt;
      logic [12:0] dly;
      logic [5:0]  edges;
      logic        sck;
      logic        sel;
      logic [1:0]  grp;
      logic        dma_busy;
      logic        dma_wr;
      logic [31:0] rdata;
      logic        done;
      sfc_pkg::sfc_state_t st;
   } sfc_reg_t;

   sfc_reg_t r;
   sfc_reg_t next_r;
   logic [3:0] ev;
   logic [3:0] p_ev;
   logic [3:0] sy1;
   logic [3:0] sy2;
   sfc_pkg::sfc_format_t fmt;
   logic tick;
   logic baud_ok;
   logic [4:0] nbits;

   // serializer status comes from its own timing: two-stage sync
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sy1 <= 4'h0;
         sy2 <= 4'h0;
         p_ev <= 4'h0;
      end else begin
         sy1 <= {OVERRUN, MODE_FAULT, TX_EMPTY, RX_FULL};
         sy2 <= sy1;
         p_ev <= sy2;
      end
   end
   // rising edges of flags become sticky events
   assign ev = sy2 & ~p_ev;

   assign fmt = sfc_pkg::sfc_format_t'(r.csf[r.grp]); // RULE18
   assign tick = r.slow ? (r.pre == sfc_pkg::SLOW_DIV) : 1'b1; // RULE14
   assign baud_ok = fmt.baud_divider > 8'h01; // RULE13
   // reserved lengths clamp to 16 rather than overrun the counter
   assign nbits = (fmt.bits > sfc_pkg::BITS_MAX) ? 5'h10 :
                  sfc_pkg::BITS_BASE + {1'b0, fmt.bits}; // RULE11

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.rdata = sfc_pkg::RST_WORD;
      next_r.pre = r.slow ? r.pre + 5'h01 : 5'h00;
      // set wins over write-one-to-clear
      if (WR && ADDR == sfc_pkg::OFS_IRQ_STATUS)
         next_r.flags = r.flags & ~WDATA[3:0];
      next_r.flags = next_r.flags | ev;
      if (WR) begin
         case (ADDR)
            sfc_pkg::OFS_IRQ_ENABLE: next_r.enable = r.enable | WDATA[3:0];
            sfc_pkg::OFS_IRQ_DISABLE:
               next_r.enable = r.enable & ~WDATA[3:0]; // RULE1
            sfc_pkg::OFS_RX_ADDR: next_r.rx_addr = WDATA; // RULE4
            sfc_pkg::OFS_RX_COUNT: next_r.rx_count = WDATA;
            sfc_pkg::OFS_TX_ADDR: next_r.tx_addr = WDATA; // RULE6
            sfc_pkg::OFS_TX_COUNT: next_r.tx_count = WDATA;
            sfc_pkg::OFS_MODE: next_r.slow = WDATA[sfc_pkg::POS_SLOW];
            default: begin
               if (ADDR >= sfc_pkg::OFS_CSF0 && ADDR <= sfc_pkg::OFS_CSF3
                   && ADDR[1:0] == 2'b00)
                  next_r.csf[ADDR[3:2]] = WDATA;
            end
         endcase
      end
      if (RD) begin
         case (ADDR)
            sfc_pkg::OFS_IRQ_STATUS: next_r.rdata = {28'h0, r.flags};
            sfc_pkg::OFS_IRQ_MASK: next_r.rdata = {28'h0, r.enable}; // RULE2
            sfc_pkg::OFS_RX_ADDR: next_r.rdata = r.rx_addr;
            sfc_pkg::OFS_RX_COUNT: next_r.rdata = r.rx_count;
            sfc_pkg::OFS_TX_ADDR: next_r.rdata = r.tx_addr;
            sfc_pkg::OFS_TX_COUNT: next_r.rdata = r.tx_count;
            sfc_pkg::OFS_MODE: next_r.rdata = {28'h0, r.slow, 3'h0};
            default: begin
               if (ADDR >= sfc_pkg::OFS_CSF0 && ADDR <= sfc_pkg::OFS_CSF3
                   && ADDR[1:0] == 2'b00)
                  next_r.rdata = r.csf[ADDR[3:2]];
            end
         endcase
      end
      // dma: receive has priority since an unread word may be overrun
      if (r.dma_busy) begin
         if (DMA_ACK) begin
            next_r.dma_busy = 1'b0;
            if (r.dma_wr) begin
               next_r.rx_addr = r.rx_addr + 32'h4;   // RULE8
               next_r.rx_count = r.rx_count - 32'h1; // RULE8
            end else begin
               next_r.tx_addr = r.tx_addr + 32'h4;   // RULE8
               next_r.tx_count = r.tx_count - 32'h1; // RULE8
            end
         end
      end else if (ev[sfc_pkg::BIT_RX_FULL] && r.rx_count != 32'h0) begin
         next_r.dma_busy = 1'b1; // RULE5
         next_r.dma_wr = 1'b1;
      end else if (ev[sfc_pkg::BIT_TX_EMPTY] && r.tx_count != 32'h0) begin
         next_r.dma_busy = 1'b1; // RULE7
         next_r.dma_wr = 1'b0;
      end
      // serial timing, advancing only on master clock ticks
      if (tick) begin
         case (r.st)
            sfc_pkg::SFC_IDLE: begin
               next_r.sck = fmt.clock_idle_level; // RULE9
               if (START && baud_ok) begin // RULE13
                  next_r.grp = PERIPH[3:2]; // RULE18
                  next_r.sel = 1'b1;
                  next_r.st = sfc_pkg::SFC_LEAD;
                  next_r.dly = (fmt.select_to_clock_delay == 8'h00) ?
                     {5'h00, fmt.baud_divider} :
                     {5'h00, fmt.select_to_clock_delay}; // RULE15
               end
            end
            sfc_pkg::SFC_LEAD: begin
               if (r.dly <= 13'h001) begin
                  next_r.st = sfc_pkg::SFC_SHIFT;
                  next_r.baud_cnt = fmt.baud_divider;
                  next_r.edges = 6'h00;
               end else
                  next_r.dly = r.dly - 13'h001;
            end
            sfc_pkg::SFC_SHIFT: begin
               // half period is baud_divider master clocks
               if (r.baud_cnt <= 8'h01) begin
                  next_r.baud_cnt = fmt.baud_divider; // RULE12
                  next_r.sck = ~r.sck;
                  next_r.edges = r.edges + 6'h01;
                  if (r.edges + 6'h01 == {nbits, 1'b0}) begin
                     next_r.st = sfc_pkg::SFC_GAP;
                     next_r.done = 1'b1;
                     next_r.dly = (fmt.inter_transfer_delay == 8'h00) ?
                        sfc_pkg::DBCT_ZERO :
                        13'(sfc_pkg::DBCT_UNIT *
                            {5'h00, fmt.inter_transfer_delay}); // RULE16
                  end
               end else
                  next_r.baud_cnt = r.baud_cnt - 8'h01;
            end
            sfc_pkg::SFC_GAP: begin
               if (r.dly <= 13'h001) begin
                  // select stays high across same-peripheral words
                  if (START && SAME_PERIPH && baud_ok) begin // RULE17
                     next_r.st = sfc_pkg::SFC_LEAD;
                     next_r.dly = 13'h001;
                  end else begin
                     next_r.sel = 1'b0; // RULE17
                     next_r.st = sfc_pkg::SFC_IDLE;
                  end
               end else
                  next_r.dly = r.dly - 13'h001;
            end
            default: next_r.st = sfc_pkg::SFC_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // edge strobes: odd edges lead, phase picks role
   logic edge_now;
   logic lead_edge;
   assign edge_now = tick && r.st == sfc_pkg::SFC_SHIFT &&
                     r.baud_cnt <= 8'h01;
   assign lead_edge = ~r.edges[0];
   assign SHIFT_OUT = edge_now &&
      (lead_edge ^ fmt.clock_sample_phase); // RULE10
   assign SAMPLE_IN = edge_now &&
      ~(lead_edge ^ fmt.clock_sample_phase); // RULE10

   assign IRQ = |(r.flags & r.enable); // RULE3
   assign RDATA = r.rdata;
   assign DMA = '{req: r.dma_busy, write: r.dma_wr,
                  addr: r.dma_wr ? r.rx_addr : r.tx_addr};
   assign SERIAL_CLOCK_LINE = r.sck;
   assign SELECT_ACTIVE = r.sel;
   assign WORD_DONE = r.done;
   assign WORD_BITS = nbits;
endmodule // sfc_top

/* design/sfc_pkg.sv */
package sfc_pkg;
   // register word offsets (byte addresses, 32-bit aligned)
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] OFS_IRQ_DISABLE = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_RX_ADDR = 8'h10;
   localparam logic [7:0] OFS_RX_COUNT = 8'h14;
   localparam logic [7:0] OFS_TX_ADDR = 8'h18;
   localparam logic [7:0] OFS_TX_COUNT = 8'h1c;
   localparam logic [7:0] OFS_CSF0 = 8'h20;
   localparam logic [7:0] OFS_CSF3 = 8'h2c;
   localparam logic [7:0] OFS_MODE = 8'h30;
   // interrupt bit positions
   localparam int BIT_RX_FULL = 0;
   localparam int BIT_TX_EMPTY = 1;
   localparam int BIT_MODE_FAULT = 2;
   localparam int BIT_OVERRUN = 3;
   // format field positions
   localparam int POS_IDLE = 0;
   localparam int POS_PHASE = 1;
   localparam int POS_BITS = 4;
   localparam int POS_BAUD = 8;
   localparam int POS_DBS = 16;
   localparam int POS_DBCT = 24;
   // mode register bit for the slow master clock
   localparam int POS_SLOW = 3;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_IRQ = 4'h0;
   // timing counts in master clock periods
   localparam logic [4:0] SLOW_DIV = 5'h1f;      // divide by 32
   localparam logic [12:0] DBCT_UNIT = 13'h020;  // 32 periods per step
   localparam logic [12:0] DBCT_ZERO = 13'h004;  // zero field: 4 periods
   localparam logic [3:0] BITS_MAX = 4'h8;
   localparam logic [4:0] BITS_BASE = 5'h08;

   typedef enum logic [2:0] {
      SFC_IDLE  = 3'b000,
      SFC_LEAD  = 3'b001,
      SFC_SHIFT = 3'b010,
      SFC_GAP   = 3'b011
   } sfc_state_t;

   // one peripheral transfer format
   typedef struct packed {
      logic [7:0] inter_transfer_delay;
      logic [7:0] select_to_clock_delay;
      logic [7:0] baud_divider;
      logic [3:0] bits;
      logic [1:0] rsvd;
      logic       clock_sample_phase;
      logic       clock_idle_level;
   } sfc_format_t;

   // DMA request toward the memory side
   typedef struct packed {
      logic        req;
      logic        write;   // 1 = store received word
      logic [31:0] addr;
   } sfc_dma_t;
endpackage

/* dv/sfc_asserts.sv */
`timescale 1ns/100ps
module sfc_asserts (
   input wire logic              MCLK,
   input wire logic              RST_N,
   input wire logic              RD,
   input wire logic [31:0]       RDATA,
   input wire sfc_pkg::sfc_dma_t DMA,
   input wire logic              DMA_ACK,
   input wire logic              SELECT_ACTIVE,
   input wire logic              SHIFT_OUT,
   input wire logic              SAMPLE_IN,
   input wire logic              WORD_DONE,
   input wire logic [4:0]        WORD_BITS
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // read data stands only after a read strobe
   rdata_quiet_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside read cycle");
   dma_hold_a: assert property (DMA.req && !DMA_ACK |=> DMA.req
      && $stable(DMA.addr) && $stable(DMA.write))
      else $error("dma request dropped or moved");
   dma_release_a: assert property (DMA.req && DMA_ACK |=> !DMA.req)
      else $error("dma request held after ack");
   // the gap keeps the select up at least four master periods
   gap_hold_a: assert property (WORD_DONE |-> SELECT_ACTIVE [*4])
      else $error("select dropped inside gap");
   done_pulse_a: assert property (WORD_DONE |=> !WORD_DONE)
      else $error("word done longer than one cycle");
   bits_range_a: assert property (WORD_BITS inside {[5'h08:5'h10]})
      else $error("word length out of range");
   edge_excl_a: assert property (!(SHIFT_OUT && SAMPLE_IN))
      else $error("shift and sample on one edge");
   pulse_sel_a: assert property (SHIFT_OUT || SAMPLE_IN |-> SELECT_ACTIVE)
      else $error("serial edge without select");
endmodule // sfc_asserts
bind sfc_top sfc_asserts u_chk (.MCLK, .RST_N, .RD, .RDATA, .DMA, .DMA_ACK,
   .SELECT_ACTIVE, .SHIFT_OUT, .SAMPLE_IN, .WORD_DONE, .WORD_BITS);

/* dv/sfc_periph_model.sv */
`timescale 1ns/100ps
module sfc_periph_model (
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic              SERIAL_CLOCK_LINE,
   input  wire logic              SELECT_ACTIVE,
   input  wire sfc_pkg::sfc_dma_t DMA,
   input  wire logic [1:0]        lag,
   output logic                   DMA_ACK,
   output int                     edges
);
   logic [1:0] wait_cnt;
   logic       last_sck;
   // memory side: answers after lag cycles, so slow acks are exercised
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         DMA_ACK <= 1'b0;
         wait_cnt <= 2'h0;
      end else begin
         DMA_ACK <= 1'b0;
         if (DMA.req && !DMA_ACK) begin
            wait_cnt <= (wait_cnt == lag) ? 2'h0 : wait_cnt + 2'h1;
            DMA_ACK <= (wait_cnt == lag);
         end
      end
   end
   // clock edges while selected; each one moves or captures a bit
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         edges <= 0;
         last_sck <= 1'b0;
      end else begin
         last_sck <= SERIAL_CLOCK_LINE;
         if (SELECT_ACTIVE && last_sck != SERIAL_CLOCK_LINE)
            edges <= edges + 1;
      end
   end
endmodule // sfc_periph_model

/* dv/spi_irq_dma_chip_select_format_test.sv */
`timescale 1ns/100ps
module spi_irq_dma_chip_select_format_test;
   logic MCLK = 0, RST_N = 0, WR = 0, RD = 0, START = 0, SAME_PERIPH = 0;
   logic RX_FULL = 0, TX_EMPTY = 0, MODE_FAULT = 0, OVERRUN = 0;
   logic IRQ, DMA_ACK, SERIAL_CLOCK_LINE, SELECT_ACTIVE, SHIFT_OUT;
   logic SAMPLE_IN, WORD_DONE;
   logic [7:0]        ADDR = 0;
   logic [31:0]       WDATA = 0, RDATA, got, a;
   logic [3:0]        PERIPH = 0, b;
   logic [4:0]        WORD_BITS;
   logic [1:0]        lag = 0;
   sfc_pkg::sfc_dma_t DMA;
   int                edges, e0, i, n_errors = 0, samples_checked = 0;
   sfc_top DUT (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ,
      .RX_FULL, .TX_EMPTY, .MODE_FAULT, .OVERRUN, .START, .SAME_PERIPH,
      .PERIPH, .DMA, .DMA_ACK, .SERIAL_CLOCK_LINE, .SELECT_ACTIVE,
      .SHIFT_OUT, .SAMPLE_IN, .WORD_DONE, .WORD_BITS);
   sfc_periph_model u_far (.MCLK, .RST_N, .SERIAL_CLOCK_LINE,
      .SELECT_ACTIVE, .DMA, .lag, .DMA_ACK, .edges);
   always #50 MCLK = ~MCLK;
   task finish_test;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", what, exp, seen);
      end
   endtask
   task wr(logic [7:0] ad, logic [31:0] d);
      @(posedge MCLK);
      ADDR <= ad;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   // read data lands at the edge that takes the strobe
   task rdc(logic [7:0] ad, logic [31:0] exp);
      @(posedge MCLK);
      ADDR <= ad;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 check("reg", RDATA, exp);
   endtask
   function automatic logic cond(int k);
      case (k)
         0: return DMA.req === 1'b1;
         1: return SELECT_ACTIVE === 1'b1;
         2: return WORD_DONE === 1'b1;
         3: return DMA.req === 1'b0;
         default: return SELECT_ACTIVE === 1'b0;
      endcase
   endfunction
   // bounded wait; a hang ends the run as a failure
   task wait_on(int k);
      int n;
      n = 0;
      while (!cond(k)) begin
         @(posedge MCLK);
         #1 n++;
         if (n > 400) begin
            n_errors++;
            finish_test();
         end
      end
   endtask
   task flag(logic rx, logic v);
      @(posedge MCLK);
      if (rx) RX_FULL <= v;
      else TX_EMPTY <= v;
   endtask
   // zero count blocks, then one word moves and the pointer steps
   task dma_word(logic rx);
      wr(rx ? sfc_pkg::OFS_RX_COUNT : sfc_pkg::OFS_TX_COUNT, 32'h0);
      flag(rx, 1'b1);
      repeat (6) @(posedge MCLK);
      #1 check("idle req", DMA.req, 1'b0);
      flag(rx, 1'b0);
      a = $urandom & 32'hffff_fffc;
      lag <= 2'($urandom_range(3));
      wr(rx ? sfc_pkg::OFS_RX_ADDR : sfc_pkg::OFS_TX_ADDR, a);
      wr(rx ? sfc_pkg::OFS_RX_COUNT : sfc_pkg::OFS_TX_COUNT, 32'h2);
      flag(rx, 1'b1);
      wait_on(0);
      check("dma addr", DMA.addr, a);
      check("dma dir", DMA.write, rx);
      wait_on(3);
      flag(rx, 1'b0);
      rdc(rx ? sfc_pkg::OFS_RX_ADDR : sfc_pkg::OFS_TX_ADDR, a + 4);
      rdc(rx ? sfc_pkg::OFS_RX_COUNT : sfc_pkg::OFS_TX_COUNT, 1);
   endtask
   initial begin
      void'($urandom(32'hc91a));
      repeat (3) @(posedge MCLK);
      RST_N <= 1'b1;
      for (i = 0; i < 6; i++)
         rdc(sfc_pkg::OFS_IRQ_MASK + 8'(4 * i), 32'h0);
      for (i = 1; i < 6; i++) begin
         a = $urandom;
         wr(sfc_pkg::OFS_IRQ_MASK + 8'(4 * i), a);
         rdc(sfc_pkg::OFS_IRQ_MASK + 8'(4 * i), a);
      end
      wr(8'h40, $urandom);
      rdc(8'h40, 32'h0);
      for (i = 0; i < 4; i++) begin
         wr(sfc_pkg::OFS_IRQ_ENABLE, 32'hf);
         wr(sfc_pkg::OFS_IRQ_DISABLE, 32'h1 << i);
         rdc(sfc_pkg::OFS_IRQ_MASK, 32'hf ^ (32'h1 << i));
      end
      wr(sfc_pkg::OFS_IRQ_DISABLE, 32'h0);
      rdc(sfc_pkg::OFS_IRQ_MASK, 32'h7);
      flag(1'b1, 1'b1);
      repeat (5) @(posedge MCLK);
      #1 check("irq on", IRQ, 1'b1);
      wr(sfc_pkg::OFS_IRQ_DISABLE, 32'h1);
      #1 check("irq masked", IRQ, 1'b0);
      flag(1'b1, 1'b0);
      wr(sfc_pkg::OFS_IRQ_DISABLE, 32'hf);
      dma_word(1'b1);
      dma_word(1'b0);
      // divider of one keeps the clock parked at its idle level
      wr(sfc_pkg::OFS_CSF0, 32'h0000_0101);
      @(posedge MCLK) START <= 1'b1;
      repeat (20) @(posedge MCLK);
      #1 check("blocked sel", SELECT_ACTIVE, 1'b0);
      check("idle sck", SERIAL_CLOCK_LINE, 1'b1);
      // drop the request so the next format write cannot start a frame
      // with the clock still moving to its new idle level
      START <= 1'b0;
      wr(sfc_pkg::OFS_MODE, 32'h8);
      rdc(sfc_pkg::OFS_MODE, 32'h8);
      wr(sfc_pkg::OFS_MODE, 32'h0);
      for (i = 0; i < 3; i++) begin
         b = (i == 0) ? 4'h8 : 4'($urandom_range(8));
         PERIPH <= 4'($urandom_range(3));
         e0 = edges;
         wr(sfc_pkg::OFS_CSF0, {16'h0, 8'h02, b, 3'h0, i[0]});
         @(posedge MCLK) START <= 1'b1;
         wait_on(1);
         START <= 1'b0;
         check("bits", WORD_BITS, 5'h08 + b);
         wait_on(2);
         wait_on(4);
         check("edges", edges - e0, 2 * (8 + b));
         check("idle", SERIAL_CLOCK_LINE, i[0]);
      end
      finish_test();
   end
endmodule // spi_irq_dma_chip_select_format_test
